// [verilog/pcr_pkg.sv]
package pcr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int NUM_CH = 6;
	localparam int CNT_W = 16;
	localparam int IDX_W = 3;

	////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] PERIOD_BASE = 8'h0c;
	localparam logic [ADDR_W-1:0] PERIOD_END = 8'h24;
	localparam logic [ADDR_W-1:0] COMPARE_BASE = 8'h24;
	localparam logic [ADDR_W-1:0] COMPARE_END = 8'h3c;
	localparam logic [ADDR_W-1:0] COUNT_BASE = 8'h88;
	localparam logic [ADDR_W-1:0] COUNT_END = 8'ha0;

	////////////////////////////////////////////////////////////////////////
	// Control register fields
	localparam int ALIGN_BIT = 31;
	localparam int GROUP_BIT = 30;
	localparam int MODE_HI = 29;
	localparam int MODE_LO = 28;
	localparam int CLEAR_BIT = 27;
	localparam int CLEAR_LANE = 3;
	localparam int DZ_BASE = 24;
	localparam int HALT_BIT = 1;
	localparam int CH_STRIDE = 4;
	localparam int RUN_OFS = 0;
	localparam int INV_OFS = 2;
	localparam int MOD_OFS = 3;
	localparam logic [DATA_W-1:0] CTRL_WMASK = 32'hf7dd_dddf;
	localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		pcr_mode_independent,
		pcr_mode_complementary,
		pcr_mode_synchronized,
		pcr_mode_reserved
	} pcr_mode_e;

	typedef enum logic [2:0] {
		pcr_reg_none,
		pcr_reg_ctrl,
		pcr_reg_period,
		pcr_reg_compare,
		pcr_reg_count
	} pcr_reg_e;

	typedef struct packed {
		pcr_reg_e kind;
		logic [IDX_W-1:0] idx;
	} pcr_dec_s;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [DATA_W-1:0] wdata;
		logic [STRB_W-1:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} pcr_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} pcr_axi_rsp_s;

endpackage

// [verilog/pcr_pwm_control.sv]
// Function
// - Alignment bit 0 gives edge-aligned counting and 1 gives center-aligned counting on all channels.
// - Group bit 1 makes channels 2 and 4 take channel 0 timing and channels 3 and 5 take channel 1 timing.
// - Mode field 00 is independent, 01 complementary, 10 synchronized, 11 reserved.
// - Writing 1 to the clear bit zeroes all 16-bit counters and the bit reads back 0; writing 0 does nothing.
// - Each dead-zone enable turns its pair 0/1, 2/3 or 4/5 into a complementary pair.
// - Each channel mode bit selects one-shot at 0 and auto-reload at 1.
// - A 0-to-1 change of a channel mode bit clears that channel period and compare.
// - Each channel inverter bit at 1 inverts that channel output.
// - Each channel enable bit at 1 runs that channel timer and at 0 stops it.
// - During debug halt with the halt behaviour bit 0 timers freeze and outputs go low; at 1 they run on.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module pcr_pwm_control (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// AXI4-Lite register port
	input wire pcr_pkg::pcr_axi_req_s axi_req,
	output pcr_pkg::pcr_axi_rsp_s axi_rsp,
	// Processor debug halt, same clock
	input wire logic debug_halt,
	// Waveforms
	output logic [pcr_pkg::NUM_CH-1:0] pwm_out
);
	import pcr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Address decode
	function automatic pcr_dec_s pcr_decode(input logic [ADDR_W-1:0] a);
		pcr_dec_s d;
		logic [ADDR_W-1:0] p;
		logic [ADDR_W-1:0] c;
		logic [ADDR_W-1:0] n;
		d.kind = pcr_reg_none;
		d.idx = '0;
		p = a - PERIOD_BASE;
		c = a - COMPARE_BASE;
		n = a - COUNT_BASE;
		if (a[1:0] != 2'h0) begin
			d.kind = pcr_reg_none;
		end else if (a == CTRL_OFS) begin
			d.kind = pcr_reg_ctrl;
		end else if (a >= PERIOD_BASE && a < PERIOD_END) begin
			d.kind = pcr_reg_period;
			d.idx = p[IDX_W+1:2];
		end else if (a >= COMPARE_BASE && a < COMPARE_END) begin
			d.kind = pcr_reg_compare;
			d.idx = c[IDX_W+1:2];
		end else if (a >= COUNT_BASE && a < COUNT_END) begin
			d.kind = pcr_reg_count;
			d.idx = n[IDX_W+1:2];
		end
		return d;
	endfunction

	function automatic logic [DATA_W-1:0] pcr_merge(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] nw,
		input logic [STRB_W-1:0] strb
	);
		logic [DATA_W-1:0] r;
		r = old;
		for (int b = 0; b < STRB_W; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Write channel: address and data taken in either order
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [DATA_W-1:0] w_data;
	logic [STRB_W-1:0] w_strb;
	logic bvalid;
	logic [1:0] bresp;
	logic wr_fire;
	pcr_dec_s wr_dec;

	assign wr_fire = aw_held && w_held;
	assign wr_dec = pcr_decode(aw_addr);

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end else if (axi_req.awvalid && axi_rsp.awready) begin
			aw_held <= 1'b1;
			aw_addr <= axi_req.awaddr;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end else if (axi_req.wvalid && axi_rsp.wready) begin
			w_held <= 1'b1;
			w_data <= axi_req.wdata;
			w_strb <= axi_req.wstrb;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= (wr_dec.kind == pcr_reg_none) ? RESP_SLVERR : RESP_OKAY;
		end else if (axi_req.bready) begin
			bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register
	logic [DATA_W-1:0] ctrl;
	logic ctrl_wr;
	logic clear_req;
	logic [NUM_CH-1:0] mode_q;
	pcr_mode_e op_mode;
	logic frozen;

	assign ctrl_wr = wr_fire && wr_dec.kind == pcr_reg_ctrl;
	// Clear is a pulse only, never stored, so it always reads 0
	assign clear_req = ctrl_wr && w_strb[CLEAR_LANE] && w_data[CLEAR_BIT];
	assign op_mode = pcr_mode_e'(ctrl[MODE_HI:MODE_LO]);
	assign frozen = debug_halt && !ctrl[HALT_BIT];

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl <= CTRL_RESET;
		end else if (ctrl_wr) begin
			// Mask drops reserved bits and the clear bit
			ctrl <= pcr_merge(ctrl, w_data, w_strb) & CTRL_WMASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-channel period, compare and counter
	logic [CNT_W-1:0] period [NUM_CH];
	logic [CNT_W-1:0] compare [NUM_CH];
	logic [CNT_W-1:0] count [NUM_CH];
	logic [NUM_CH-1:0] timed;
	logic [NUM_CH-1:0] paired;

	genvar i;
	generate
		for (i = 0; i < NUM_CH; i++) begin : g_ch
			localparam int SRC = (i >= 2) ? (i % 2) : i;
			logic reload;
			logic run;
			logic mode_rise;
			logic down;
			logic done;
			logic use_grp;
			logic [CNT_W-1:0] t_cnt;
			logic [CNT_W-1:0] t_cmp;
			logic t_run;

			assign reload = ctrl[CH_STRIDE*i+MOD_OFS];
			assign run = ctrl[CH_STRIDE*i+RUN_OFS];
			assign mode_rise = reload && !mode_q[i];

			always_ff @(posedge clk) begin
				if (reset) begin
					mode_q[i] <= 1'b0;
				end else begin
					mode_q[i] <= reload;
				end
			end

			// The mode edge is seen a cycle after the write, so it wins
			always_ff @(posedge clk) begin
				if (reset || mode_rise) begin
					period[i] <= CNT_RESET;
					compare[i] <= CNT_RESET;
				end else if (wr_fire && wr_dec.idx == IDX_W'(i)) begin
					if (wr_dec.kind == pcr_reg_period) begin
						period[i] <= CNT_W'(pcr_merge({16'h0000, period[i]},
							w_data, w_strb));
					end else if (wr_dec.kind == pcr_reg_compare) begin
						compare[i] <= CNT_W'(pcr_merge({16'h0000, compare[i]},
							w_data, w_strb));
					end
				end
			end

			always_ff @(posedge clk) begin
				if (reset || clear_req) begin
					count[i] <= CNT_RESET;
					down <= 1'b0;
					done <= 1'b0;
				end else if (!run) begin
					// Stopped timer keeps its count; a restart resumes there
					done <= 1'b0;
				end else if (frozen || done) begin
					down <= down;
				end else if (!ctrl[ALIGN_BIT]) begin
					if (count[i] >= period[i]) begin
						if (reload) begin
							count[i] <= CNT_RESET;
						end else begin
							done <= 1'b1;
						end
					end else begin
						count[i] <= count[i] + 16'h0001;
					end
				end else if (!down) begin
					if (count[i] >= period[i]) begin
						down <= 1'b1;
						if (count[i] != CNT_RESET) begin
							count[i] <= count[i] - 16'h0001;
						end
					end else begin
						count[i] <= count[i] + 16'h0001;
					end
				end else if (count[i] == CNT_RESET) begin
					down <= 1'b0;
					done <= !reload;
				end else begin
					count[i] <= count[i] - 16'h0001;
				end
			end

			// Grouped channels borrow the leader's counter and compare
			assign use_grp = ctrl[GROUP_BIT] && (SRC != i);
			assign t_cnt = use_grp ? count[SRC] : count[i];
			assign t_cmp = use_grp ? compare[SRC] : compare[i];
			assign t_run = use_grp ? ctrl[CH_STRIDE*SRC+RUN_OFS] : run;
			assign timed[i] = t_run && (t_cnt <= t_cmp);

			if (i % 2 == 1) begin : g_odd
				logic dz;
				assign dz = ctrl[DZ_BASE + i/2];
				always_comb begin
					if (dz || op_mode == pcr_mode_complementary) begin
						paired[i] = run && !timed[i-1];
					end else if (op_mode == pcr_mode_synchronized) begin
						paired[i] = timed[i-1];
					end else begin
						paired[i] = timed[i];
					end
				end
			end else begin : g_even
				assign paired[i] = timed[i];
			end

			always_ff @(posedge clk) begin
				if (reset || frozen) begin
					pwm_out[i] <= 1'b0;
				end else begin
					pwm_out[i] <= paired[i] ^ ctrl[CH_STRIDE*i+INV_OFS];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Read channel, answer one cycle after the address is taken
	logic rvalid;
	logic [DATA_W-1:0] rdata;
	logic [1:0] rresp;
	pcr_dec_s rd_dec;

	assign rd_dec = pcr_decode(axi_req.araddr);

	always_ff @(posedge clk) begin
		if (reset) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (axi_req.arvalid && !rvalid) begin
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			unique case (rd_dec.kind)
				pcr_reg_ctrl: rdata <= ctrl;
				pcr_reg_period: rdata <= {16'h0000, period[rd_dec.idx]};
				pcr_reg_compare: rdata <= {16'h0000, compare[rd_dec.idx]};
				pcr_reg_count: rdata <= {16'h0000, count[rd_dec.idx]};
				default: begin
					rdata <= '0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (axi_req.rready) begin
			rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus answers
	always_comb begin
		axi_rsp.awready = !aw_held && !bvalid;
		axi_rsp.wready = !w_held && !bvalid;
		axi_rsp.bvalid = bvalid;
		axi_rsp.bresp = bresp;
		axi_rsp.arready = !rvalid;
		axi_rsp.rvalid = rvalid;
		axi_rsp.rdata = rdata;
		axi_rsp.rresp = rresp;
	end

endmodule

// [dv/pcr_pwm_control_properties.sv]
`timescale 1ns/1ps
module pcr_pwm_control_checker import pcr_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Watched ports
	input wire pcr_pkg::pcr_axi_req_s axi_req,
	input wire pcr_pkg::pcr_axi_rsp_s axi_rsp,
	input wire logic debug_halt,
	input wire logic [pcr_pkg::NUM_CH-1:0] pwm_out
);
	logic [31:0] sh, wd, bm, next_sh;
	logic [7:0] wa;
	logic [3:0] ws;
	logic aw_f, w_f, rd_ctrl;
	logic [5:0] inv;
	////////////////////////////////////////////////////////////////////////
	// Shadow of the control register, updated on the write edge
	assign bm = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
	assign next_sh = (sh & ~bm) | (wd & bm & CTRL_WMASK);
	always_comb begin
		for (int i = 0; i < NUM_CH; i++)
			inv[i] = sh[i * CH_STRIDE + INV_OFS];
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			aw_f <= 1'b0;
			w_f <= 1'b0;
			sh <= CTRL_RESET;
		end else begin
			if (axi_req.awvalid && axi_rsp.awready) begin
				aw_f <= 1'b1;
				wa <= axi_req.awaddr;
			end
			if (axi_req.wvalid && axi_rsp.wready) begin
				w_f <= 1'b1;
				wd <= axi_req.wdata;
				ws <= axi_req.wstrb;
			end
			if (aw_f && w_f) begin
				aw_f <= 1'b0;
				w_f <= 1'b0;
				if (wa == CTRL_OFS)
					sh <= next_sh;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (axi_req.arvalid && axi_rsp.arready)
			rd_ctrl <= axi_req.araddr == CTRL_OFS;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	ctrl_readback_a: assert property (axi_rsp.rvalid && rd_ctrl
		|-> axi_rsp.rdata == sh) else $error("control readback wrong");
	rsv_zero_a: assert property (axi_rsp.rvalid && rd_ctrl
		|-> (axi_rsp.rdata & ~CTRL_WMASK) == 32'h0) else $error("reserved set");
	halt_low_a: assert property (debug_halt && !sh[HALT_BIT]
		|=> pwm_out == 6'h00) else $error("outputs live in halt");
	stop_idle_a: assert property (!debug_halt && sh[30:24] == 7'h00 &&
		(sh & 32'h0011_1111) == 32'h0 |=> pwm_out == $past(inv))
		else $error("stopped output not idle level");
	write_answer_a: assert property (aw_f && w_f |=> axi_rsp.bvalid)
		else $error("write answer late");
	ctrl_okay_a: assert property (axi_rsp.bvalid && wa == CTRL_OFS
		|-> axi_rsp.bresp == RESP_OKAY) else $error("control write refused");
	busy_refuse_a: assert property (axi_rsp.bvalid
		|-> !axi_rsp.awready && !axi_rsp.wready) else $error("taken while busy");
	read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready
		|=> axi_rsp.rvalid && !axi_rsp.arready) else $error("read answer late");
endmodule
bind pcr_pwm_control pcr_pwm_control_checker pcr_pwm_control_checker_inst (
	.clk(clk), .reset(reset), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.debug_halt(debug_halt), .pwm_out(pwm_out));

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import pcr_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic debug_halt = 1'b0;
	pcr_axi_req_s req = '0;
	pcr_axi_rsp_s rsp;
	logic [NUM_CH-1:0] pwm_out;
	logic [33:0] rq[$];
	logic [1:0] wq[$];
	int fails = 0;
	int tests_run = 0;
	int hi;
	logic [31:0] ex, v, bm;
	logic [3:0] s;
	logic [31:0] cv[8] = '{32'h89, 32'h8d, 32'h8c, 32'h4000_0089,
		32'h1000_0099, 32'h0100_0099, 32'h2000_0099, 32'h3000_0099};
	logic [5:0] pv[8] = '{6'h01, 6'h00, 6'h01, 6'h15, 6'h01, 6'h01, 6'h03,
		6'h03};
	always #50 clk = ~clk;
	pcr_pwm_control pcr_pwm_control_inst (.clk(clk), .reset(reset),
		.axi_req(req), .axi_rsp(rsp), .debug_halt(debug_halt),
		.pwm_out(pwm_out));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [33:0] e, g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Both halves offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] st, input logic [1:0] r);
		int n = 0;
		@(posedge clk);
		wq.push_back(r);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= st;
		req.bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid && n < 40);
		req.bready <= 1'b0;
		if (!rsp.bvalid) begin
			fails++;
			give_verdict();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n = 0;
		@(posedge clk);
		rq.push_back({r, d});
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid && n < 40);
		req.rready <= 1'b0;
		if (!rsp.rvalid) begin
			fails++;
			give_verdict();
		end
	endtask
	task automatic pw(input logic [5:0] e);
		repeat (4) @(posedge clk);
		#1 chk("pwm_out", {28'h0, e}, {28'h0, pwm_out});
	endtask
	// Answers taken off the queues as they appear
	always @(posedge clk) begin
		if (rsp.bvalid && req.bready)
			chk("bresp", {32'h0, wq.pop_front()}, {32'h0, rsp.bresp});
		if (rsp.rvalid && req.rready)
			chk("rdata", rq.pop_front(), {rsp.rresp, rsp.rdata});
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(37293));
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rd(CTRL_OFS, 32'h0, RESP_OKAY);
		ex = CTRL_RESET;
		for (int i = 0; i < 8; i++) begin
			v = $urandom;
			s = 4'($urandom);
			s[3] = 1'b1;
			v[29:28] = i[1:0];
			bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
			ex = (ex & ~bm) | (v & bm & CTRL_WMASK);
			wr(CTRL_OFS, v, s, RESP_OKAY);
			rd(CTRL_OFS, ex, RESP_OKAY);
		end
		wr(8'h40, 32'h1, 4'hf, RESP_SLVERR);
		rd(8'h0a, 32'h0, RESP_SLVERR);
		// Mode bit rise on channel 4 only
		wr(CTRL_OFS, 32'h0, 4'hf, RESP_OKAY);
		wr(PERIOD_BASE + 8'h10, 32'h5, 4'hf, RESP_OKAY);
		wr(COMPARE_BASE + 8'h10, 32'h3, 4'hf, RESP_OKAY);
		wr(PERIOD_BASE + 8'h14, 32'h7, 4'hf, RESP_OKAY);
		wr(CTRL_OFS, 32'h0008_0000, 4'hf, RESP_OKAY);
		rd(PERIOD_BASE + 8'h10, 32'h0, RESP_OKAY);
		rd(COMPARE_BASE + 8'h10, 32'h0, RESP_OKAY);
		rd(PERIOD_BASE + 8'h14, 32'h7, RESP_OKAY);
		// Short period over 28 cycles: edge repeats every 4, center every 7
		wr(CTRL_OFS, 32'h88, 4'hf, RESP_OKAY);
		wr(PERIOD_BASE, 32'h3, 4'hf, RESP_OKAY);
		wr(COMPARE_BASE, 32'h0, 4'hf, RESP_OKAY);
		for (int k = 0; k < 2; k++) begin
			wr(CTRL_OFS, k ? 32'h8000_0089 : 32'h89, 4'hf, RESP_OKAY);
			repeat (8) @(posedge clk);
			hi = 0;
			repeat (28) begin
				@(posedge clk);
				#1 hi += pwm_out[0];
			end
			chk("high count", k ? 34'd8 : 34'd7, 34'(hi));
		end
		// One-shot stops at the period and the output stays low
		wr(CTRL_OFS, 32'h81, 4'hf, RESP_OKAY);
		repeat (8) @(posedge clk);
		rd(COUNT_BASE, 32'h3, RESP_OKAY);
		pw(6'h00);
		// Stop drops the finished state; the mode rise clears period 0
		wr(CTRL_OFS, 32'h88, 4'hf, RESP_OKAY);
		for (int c = 0; c < 4; c++)
			wr(PERIOD_BASE + 8'(4 * (c % 2) + 24 * (c / 2)), 32'hffff, 4'hf,
				RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			wr(CTRL_OFS, cv[i], 4'hf, RESP_OKAY);
			pw(pv[i]);
		end
		// Halt: safe setting drops outputs, normal keeps them
		for (int k = 0; k < 2; k++) begin
			wr(CTRL_OFS, k ? 32'h8b : 32'h89, 4'hf, RESP_OKAY);
			@(posedge clk);
			debug_halt <= 1'b1;
			pw(k ? 6'h01 : 6'h00);
			@(posedge clk);
			debug_halt <= 1'b0;
		end
		// Clear pulse zeroes the stopped count; a count write is ignored and clear reads 0
		wr(CTRL_OFS, 32'h88, 4'hf, RESP_OKAY);
		wr(CTRL_OFS, 32'h0800_0088, 4'hf, RESP_OKAY);
		wr(COUNT_BASE, 32'h55, 4'hf, RESP_OKAY);
		rd(COUNT_BASE, 32'h0, RESP_OKAY);
		rd(CTRL_OFS, 32'h88, RESP_OKAY);
		repeat (4) @(posedge clk);
		give_verdict();
	end
endmodule
